// [design/rtq_core.sv]
// residual transform, quantization, scan and reconstruction datapath
// How it works
// - forward 1-D transform uses weights 13, 17 and 7 in fixed sign patterns
// - inverse 1-D transform uses transposed weights, exact integer arithmetic
// - transforms carry no normalisation; round trip gain of 676 per dimension goes to quantizer
// - 4x4 transforms run along columns then rows with one kernel
// - 2x2 chroma dc forward transform is signed sum of four, halved
// - 2x2 chroma dc inverse uses the same sign patterns, halved
// - double scan only for intra luma with step index below 24
// - double scan splits block in two parts, each with own block end
// - 32 step indices, step doubles every six, no dead zone
// - chroma index equals luma up to 17, then follows fixed map
// - level is coefficient times table plus rounding, shifted down 20
// - dequantization multiplies level by inverse table entry
// - reconstruction shifts right 20 with rounding, all in 32 bits
// - chroma dc values quantized alone, scanned in fixed order
// - chroma ac scans 15 coefficients, runs never above 14
// - events pair a zero run with a nonzero level, then a block end
// - block end is sent as the single-bit universal codeword
// - luma uses the received step index, chroma the mapped one
`timescale 1ns/1ps
module rtq_core
  import rtq_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire rtq_op_t op_i,
  input wire logic [4:0] quant_step_index_i,
  input wire logic luma_i,
  input wire logic intra_i,
  input wire logic [511:0] blk_i,
  input wire logic [127:0] pred_i,
  output logic busy_o,
  output logic done_o,
  output logic evt_valid_o,
  output logic [3:0] evt_run_o,
  output logic signed [31:0] evt_level_o,
  output logic block_end_marker_o,
  output logic end_codeword_o,
  output logic [127:0] recon_o,
  output logic [127:0] chroma_dc_o
);

  rtq_state_t state;
  rtq_op_t op;
  logic [4:0] step;
  logic dbl;
  logic chroma_ac;
  logic [4:0] pos;
  logic [4:0] seg_end;
  logic [3:0] run;
  logic signed [31:0] mat [16];
  logic signed [31:0] dc_h [4];
  logic [4:0] step_eff;
  logic [3:0] idx;
  logic signed [31:0] cur;

  rtq_tr_if tr_bus ();

  rtq_tr4 u_tr (
    .tr(tr_bus)
  );

  // chroma follows the luma index up to 17, then the compressed map
  function automatic logic [4:0] chroma_step(input logic [4:0] q);
    chroma_step = (q <= RTQ_CQP_SAME_MAX) ? q : RTQ_CQP_HIGH[4'(q - RTQ_CQP_BASE)];
  endfunction : chroma_step

  // rounding quantizer on the magnitude keeps it symmetric and free of a dead zone
  function automatic logic signed [31:0] quant(input logic signed [31:0] k, input logic [4:0] q);
    logic [31:0] mag;
    logic [63:0] prod;
    mag = k[31] ? 32'(-k) : 32'(k);
    prod = 64'(mag) * 64'(RTQ_QTAB[q]) + RTQ_QROUND;
    prod = prod >> RTQ_QSHIFT;
    quant = k[31] ? -32'(prod[31:0]) : 32'(prod[31:0]);
  endfunction : quant

  function automatic logic signed [31:0] dequant(input logic signed [31:0] l, input logic [4:0] q);
    dequant = 32'(l * $signed({14'h0, RTQ_DQTAB[q]}));
  endfunction : dequant

  // halving rounds toward zero, as integer division does
  function automatic logic signed [31:0] half(input logic signed [31:0] x);
    half = x[31] ? -((-x) >>> 1) : (x >>> 1);
  endfunction : half

  // final shift with rounding, then prediction added and clipped
  function automatic logic [7:0] recon(input logic signed [31:0] x, input logic [7:0] p);
    logic signed [31:0] s;
    s = ((x + RTQ_RROUND) >>> RTQ_QSHIFT) + $signed({24'h0, p});
    if (s < 0) begin
      recon = 8'h00;
    end else if (s > RTQ_PIX_MAX) begin
      recon = 8'hFF;
    end else begin
      recon = s[7:0];
    end
  endfunction : recon

  // effective step index: luma uses the stream value, chroma the mapped one
  assign step_eff = (luma_i && (op_i == RTQ_OP_FWD || op_i == RTQ_OP_INV)) ? quant_step_index_i
                                                                            : chroma_step(quant_step_index_i);

  // transform unit always sees the working matrix; direction follows the state
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      tr_bus.m[i] = mat[i];
    end
    tr_bus.inv = (op == RTQ_OP_INV);
    tr_bus.rows = (state == RTQ_S_ROW);
  end

  // 2x2 sum and difference; forward and inverse share the sign patterns
  always_comb begin
    dc_h[0] = half(mat[0] + mat[1] + mat[2] + mat[3]);
    dc_h[1] = half(mat[0] - mat[1] + mat[2] - mat[3]);
    dc_h[2] = half(mat[0] + mat[1] - mat[2] - mat[3]);
    dc_h[3] = half(mat[0] - mat[1] - mat[2] + mat[3]);
  end

  // scan lookup; dc blocks scan in stored order
  always_comb begin
    if (op == RTQ_OP_DCF) begin
      idx = pos[3:0];
    end else if (dbl) begin
      idx = RTQ_SCAN_DOUBLE[pos[3:0]];
    end else begin
      idx = RTQ_SCAN_SINGLE[pos[3:0]];
    end
    cur = mat[idx];
  end

  // sequencing
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= RTQ_S_IDLE;
    end else begin
      unique case (state)
        RTQ_S_IDLE: begin
          if (start_i) begin
            unique case (op_i)
              RTQ_OP_FWD, RTQ_OP_INV: state <= RTQ_S_COL;
              RTQ_OP_DCF, RTQ_OP_DCI: state <= RTQ_S_DC;
            endcase
          end
        end
        RTQ_S_COL: state <= RTQ_S_ROW;
        RTQ_S_ROW: state <= (op == RTQ_OP_INV) ? RTQ_S_REC : RTQ_S_QNT;
        RTQ_S_DC: state <= (op == RTQ_OP_DCI) ? RTQ_S_IDLE : RTQ_S_QNT;
        RTQ_S_QNT: state <= RTQ_S_SCAN;
        RTQ_S_SCAN: begin
          if (pos == seg_end && seg_end != RTQ_SEG_HALF) begin
            state <= RTQ_S_IDLE;
          end
        end
        RTQ_S_REC: state <= RTQ_S_IDLE;
      endcase
    end
  end

  // per-block settings caught at start
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op <= RTQ_OP_FWD;
      step <= 5'h00;
      dbl <= 1'b0;
      chroma_ac <= 1'b0;
    end else if (state == RTQ_S_IDLE && start_i) begin
      op <= op_i;
      step <= step_eff;
      dbl <= (op_i == RTQ_OP_FWD) && intra_i && luma_i && (quant_step_index_i < RTQ_DBL_STEP_LIMIT);
      chroma_ac <= (op_i == RTQ_OP_FWD) && !luma_i;
    end
  end

  // working matrix; dequantization happens as levels are loaded
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 16; i++) begin
        mat[i] <= 32'h0000_0000;
      end
    end else begin
      unique case (state)
        RTQ_S_IDLE: begin
          if (start_i) begin
            for (int i = 0; i < 16; i++) begin
              if (op_i == RTQ_OP_INV || op_i == RTQ_OP_DCI) begin
                mat[i] <= dequant(blk_i[32*i +: 32], step_eff);
              end else begin
                mat[i] <= blk_i[32*i +: 32];
              end
            end
          end
        end
        RTQ_S_COL, RTQ_S_ROW: begin
          for (int i = 0; i < 16; i++) begin
            mat[i] <= tr_bus.r[i];
          end
        end
        RTQ_S_DC: begin
          for (int i = 0; i < 4; i++) begin
            mat[i] <= dc_h[i];
          end
        end
        RTQ_S_QNT: begin
          for (int i = 0; i < 16; i++) begin
            mat[i] <= quant(mat[i], step);
          end
        end
        default: ;
      endcase
    end
  end

  // scan position, segment end and zero run
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos <= 5'h00;
      seg_end <= RTQ_SEG_FULL;
      run <= 4'h0;
    end else if (state == RTQ_S_QNT) begin
      pos <= chroma_ac ? RTQ_AC_FIRST : 5'h00;
      seg_end <= (op == RTQ_OP_DCF) ? RTQ_SEG_DC : (dbl ? RTQ_SEG_HALF : RTQ_SEG_FULL);
      run <= 4'h0;
    end else if (state == RTQ_S_SCAN) begin
      if (pos == seg_end) begin
        seg_end <= RTQ_SEG_FULL;  // second part starts fresh
        run <= 4'h0;
      end else begin
        pos <= pos + 5'h01;
        run <= (cur != 0) ? 4'h0 : run + 4'h1;
      end
    end
  end

  // event outputs, one per cycle; zero coefficients emit nothing
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_valid_o <= 1'b0;
      evt_run_o <= 4'h0;
      evt_level_o <= 32'h0000_0000;
      block_end_marker_o <= 1'b0;
      end_codeword_o <= 1'b0;
    end else begin
      evt_valid_o <= 1'b0;
      block_end_marker_o <= 1'b0;
      end_codeword_o <= 1'b0;
      evt_run_o <= 4'h0;
      evt_level_o <= 32'h0000_0000;
      if (state == RTQ_S_SCAN) begin
        if (pos == seg_end) begin
          evt_valid_o <= 1'b1;
          block_end_marker_o <= 1'b1;
          end_codeword_o <= RTQ_END_CODEWORD;
        end else if (cur != 0) begin
          evt_valid_o <= 1'b1;
          evt_run_o <= run;
          evt_level_o <= cur;
        end
      end
    end
  end

  // reconstructed samples and chroma dc results
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      recon_o <= 128'h0;
      chroma_dc_o <= 128'h0;
    end else if (state == RTQ_S_REC) begin
      for (int i = 0; i < 16; i++) begin
        recon_o[8*i +: 8] <= recon(mat[i], pred_i[8*i +: 8]);
      end
    end else if (state == RTQ_S_DC && op == RTQ_OP_DCI) begin
      for (int i = 0; i < 4; i++) begin
        chroma_dc_o[32*i +: 32] <= dc_h[i];
      end
    end
  end

  // status: done pulses in the cycle after the last working state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= (state == RTQ_S_IDLE) ? start_i : !(
        (state == RTQ_S_REC) ||
        (state == RTQ_S_DC && op == RTQ_OP_DCI) ||
        (state == RTQ_S_SCAN && pos == seg_end && seg_end != RTQ_SEG_HALF));
      done_o <= (state == RTQ_S_REC) || (state == RTQ_S_DC && op == RTQ_OP_DCI) ||
                (state == RTQ_S_SCAN && pos == seg_end && seg_end != RTQ_SEG_HALF);
    end
  end

  // helper: block ends seen in the current forward block
  logic [1:0] ends_seen;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ends_seen <= 2'h0;
    end else if (state == RTQ_S_QNT) begin
      ends_seen <= 2'h0;
    end else if (block_end_marker_o) begin
      ends_seen <= ends_seen + 2'h1;
    end
  end

  // helper: an accepted start whose step index goes through the chroma map
  logic chroma_start;
  assign chroma_start = state == RTQ_S_IDLE && start_i && !(luma_i && (op_i == RTQ_OP_FWD || op_i == RTQ_OP_INV));

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // checks look at the caught settings, since a back-to-back start may change the pins at once
  chroma_map_low_a: assert property (chroma_start && quant_step_index_i <= RTQ_CQP_SAME_MAX |=>
    step == $past(quant_step_index_i)) else $error("chroma index differs below 18");
  chroma_map_top_a: assert property (chroma_start && quant_step_index_i == 5'h1F |=> step == 5'h19)
    else $error("chroma index for 31 is not 25");
  dbl_select_a: assert property (state == RTQ_S_IDLE && start_i && op_i == RTQ_OP_FWD |=>
    dbl == ($past(intra_i) && $past(luma_i) && $past(quant_step_index_i) < 5'h18))
    else $error("scan mode chosen wrongly");
  sep_passes_a: assert property (state == RTQ_S_COL |=>
    state == RTQ_S_ROW ##1 state inside {RTQ_S_QNT, RTQ_S_REC}) else $error("column pass not followed by row pass");
  fwd_weight_a: assert property (state == RTQ_S_COL && op == RTQ_OP_FWD |=>
    mat[4] == 32'(RTQ_W17 * $past(mat[0]) + RTQ_W7 * $past(mat[4]) - RTQ_W7 * $past(mat[8]) - RTQ_W17 * $past(mat[12])))
    else $error("forward column weights wrong");
  dbl_ends_a: assert property ($rose(done_o) && op == RTQ_OP_FWD |=>
    ends_seen == ($past(dbl) ? 2'h2 : 2'h1)) else $error("wrong count of block ends");
  event_pair_a: assert property (evt_valid_o && !block_end_marker_o |-> evt_level_o != 0)
    else $error("event with zero level");
  end_code_a: assert property (block_end_marker_o |-> evt_valid_o && end_codeword_o && evt_level_o == 0)
    else $error("block end not one-bit code");
  ac_run_a: assert property (evt_valid_o && chroma_ac |-> evt_run_o <= 4'hE)
    else $error("chroma ac run above 14");
  inv_latency_a: assert property (state == RTQ_S_IDLE && start_i && op_i == RTQ_OP_INV |-> ##4 done_o)
    else $error("reconstruction not done in four cycles");
  dc_inv_a: assert property (state == RTQ_S_IDLE && start_i && op_i == RTQ_OP_DCI |->
    ##1 busy_o ##1 done_o && !busy_o) else $error("chroma dc inverse late");

  cov_dbl_c: cover property (state == RTQ_S_SCAN && dbl ##[1:40] done_o);
  cov_dcf_c: cover property (op == RTQ_OP_DCF && evt_valid_o && !block_end_marker_o);
  cov_rec_c: cover property (state == RTQ_S_REC ##1 done_o);
  cov_ac_c: cover property (chroma_ac && evt_valid_o && evt_run_o == 4'hE);

endmodule : rtq_core

// [design/rtq_pkg.sv]
// shared constants, tables and types for the residual transform and quantization datapath
package rtq_pkg;

  // operation selected at start
  typedef enum logic [1:0] {
    RTQ_OP_FWD,  // 4x4 residual -> transform -> quantize -> run/level events
    RTQ_OP_INV,  // 4x4 levels -> dequantize -> inverse transform -> reconstruct
    RTQ_OP_DCF,  // 2x2 chroma dc -> transform -> quantize -> events
    RTQ_OP_DCI   // 2x2 chroma dc levels -> dequantize -> inverse transform
  } rtq_op_t;

  typedef enum logic [2:0] {
    RTQ_S_IDLE, RTQ_S_COL, RTQ_S_ROW, RTQ_S_DC, RTQ_S_QNT, RTQ_S_SCAN, RTQ_S_REC
  } rtq_state_t;

  // transform weights
  localparam int RTQ_W13 = 13;
  localparam int RTQ_W17 = 17;
  localparam int RTQ_W7 = 7;

  // quantization scaling
  localparam int RTQ_QSHIFT = 20;
  localparam logic [63:0] RTQ_QROUND = 64'h0000_0000_0008_0000;  // f = 0.5 in 2^20 units
  localparam logic signed [31:0] RTQ_RROUND = 32'h0008_0000;     // rounding for final shift
  localparam logic [4:0] RTQ_DBL_STEP_LIMIT = 5'h18;             // 24
  localparam logic [4:0] RTQ_CQP_SAME_MAX = 5'h11;               // 17
  localparam logic [4:0] RTQ_CQP_BASE = 5'h12;                   // 18
  localparam logic signed [31:0] RTQ_PIX_MAX = 32'h0000_00FF;

  // scan segment bounds, in scan positions
  localparam logic [4:0] RTQ_SEG_FULL = 5'h10;
  localparam logic [4:0] RTQ_SEG_HALF = 5'h08;
  localparam logic [4:0] RTQ_SEG_DC = 5'h04;
  localparam logic [4:0] RTQ_AC_FIRST = 5'h01;

  // block end travels as code number 0, the single-bit codeword
  localparam logic RTQ_END_CODEWORD = 1'h1;

  // forward quantization table, index = step index
  localparam logic [9:0] RTQ_QTAB [32] = '{
    10'd620, 10'd553, 10'd492, 10'd439, 10'd391, 10'd348, 10'd310, 10'd276,
    10'd246, 10'd219, 10'd195, 10'd174, 10'd155, 10'd138, 10'd123, 10'd110,
    10'd98, 10'd87, 10'd78, 10'd69, 10'd62, 10'd55, 10'd49, 10'd44,
    10'd39, 10'd35, 10'd31, 10'd27, 10'd24, 10'd22, 10'd19, 10'd17};

  // dequantization table
  localparam logic [17:0] RTQ_DQTAB [32] = '{
    18'd3881, 18'd4351, 18'd4890, 18'd5481, 18'd6154, 18'd6914, 18'd7761, 18'd8718,
    18'd9781, 18'd10987, 18'd12339, 18'd13828, 18'd15523, 18'd17435, 18'd19561, 18'd21873,
    18'd24552, 18'd27656, 18'd30847, 18'd34870, 18'd38807, 18'd43747, 18'd49103, 18'd54683,
    18'd61694, 18'd68745, 18'd77615, 18'd89113, 18'd100253, 18'd109366, 18'd126635, 18'd141533};

  // chroma step index for luma indices 18..31
  localparam logic [4:0] RTQ_CQP_HIGH [14] = '{
    5'd17, 5'd18, 5'd19, 5'd20, 5'd20, 5'd21, 5'd22, 5'd22, 5'd23, 5'd23, 5'd24, 5'd24, 5'd25, 5'd25};

  // scan tables, entries are raster positions (row * 4 + column)
  localparam logic [3:0] RTQ_SCAN_SINGLE [16] = '{
    4'h0, 4'h1, 4'h4, 4'h8, 4'h5, 4'h2, 4'h3, 4'h6, 4'h9, 4'hC, 4'hD, 4'hA, 4'h7, 4'hB, 4'hE, 4'hF};
  // first eight entries form the first part, last eight the second
  localparam logic [3:0] RTQ_SCAN_DOUBLE [16] = '{
    4'h0, 4'h4, 4'h1, 4'h8, 4'hC, 4'h5, 4'h9, 4'hD, 4'h2, 4'h6, 4'h3, 4'hA, 4'hE, 4'h7, 4'hB, 4'hF};

endpackage : rtq_pkg

// [design/rtq_tr4.sv]
// one separable pass of the 4x4 integer transform over all four lanes
`timescale 1ns/1ps
module rtq_tr4
  import rtq_pkg::*;
(
  rtq_tr_if.unit tr
);

  // the one-dimensional kernel; no normalisation, gain is carried to the quantizer
  function automatic void tr1(input logic inv,
                              input logic signed [31:0] a, b, c, d,
                              output logic signed [31:0] y0, y1, y2, y3);
    if (!inv) begin
      y0 = 32'(RTQ_W13 * (a + b + c + d));
      y1 = 32'(RTQ_W17 * (a - d) + RTQ_W7 * (b - c));
      y2 = 32'(RTQ_W13 * (a - b - c + d));
      y3 = 32'(RTQ_W7 * (a - d) + RTQ_W17 * (c - b));
    end else begin
      y0 = 32'(RTQ_W13 * (a + c) + RTQ_W17 * b + RTQ_W7 * d);
      y1 = 32'(RTQ_W13 * (a - c) + RTQ_W7 * b - RTQ_W17 * d);
      y2 = 32'(RTQ_W13 * (a - c) - RTQ_W7 * b + RTQ_W17 * d);
      y3 = 32'(RTQ_W13 * (a + c) - RTQ_W17 * b - RTQ_W7 * d);
    end
  endfunction : tr1

  // same kernel along columns or rows, so both directions match exactly
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      if (tr.rows) begin
        tr1(tr.inv, tr.m[4*l], tr.m[4*l+1], tr.m[4*l+2], tr.m[4*l+3],
            tr.r[4*l], tr.r[4*l+1], tr.r[4*l+2], tr.r[4*l+3]);
      end else begin
        tr1(tr.inv, tr.m[l], tr.m[l+4], tr.m[l+8], tr.m[l+12],
            tr.r[l], tr.r[l+4], tr.r[l+8], tr.r[l+12]);
      end
    end
  end

endmodule : rtq_tr4

// [design/rtq_tr_if.sv]
// carrier between the core and its separable transform pass unit
`timescale 1ns/1ps
interface rtq_tr_if;
  logic signed [31:0] m [16];  // matrix in, raster order
  logic signed [31:0] r [16];  // matrix out after one pass
  logic inv;                   // 1 selects the inverse weights
  logic rows;                  // 1 transforms along rows, 0 along columns
  modport core (output m, output inv, output rows, input r);
  modport unit (input m, input inv, input rows, output r);
endinterface : rtq_tr_if

// [tb/rtq_far_side.sv]
// far-side model: prediction source that keeps its samples valid only while an operation runs
`timescale 1ns/1ps
module rtq_far_side (
  input wire logic clock_i,
  input wire logic busy_i,
  output logic [127:0] pred_o
);
  logic [127:0] pred = 128'h0;
  logic [127:0] junk = 128'h5A5A_0F0F_3C3C_9696_A5A5_F0F0_C3C3_6969;
  // outside an operation the lines carry a moving pattern, so a late sample of prediction shows up
  always @(posedge clock_i) begin
    junk <= {junk[126:0], ~junk[127]};
  end
  // prediction that reconstruction adds before clipping
  assign pred_o = (busy_i === 1'h1) ? pred : junk;
endmodule : rtq_far_side

// [tb/test_residual_transform_quant.sv]
// self-checking bench for the residual transform and quantization datapath
`timescale 1ns/1ps
module test_residual_transform_quant
  import rtq_pkg::*;
;
  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  logic start_i = 1'h0;
  rtq_op_t op_i = RTQ_OP_FWD;
  logic [4:0] step_i = 5'h00;
  logic luma_i = 1'h0;
  logic intra_i = 1'h0;
  logic [511:0] blk_i = 512'h0;
  logic [127:0] pred_i;
  logic busy_o, done_o, evt_valid_o, block_end_marker_o, end_codeword_o;
  logic [3:0] evt_run_o;
  logic signed [31:0] evt_level_o;
  logic [127:0] recon_o, chroma_dc_o;
  logic [37:0] exq [$];
  logic [37:0] gotq [$];
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h70C2;
  int cycles = 0;
  bit poke = 1'h0;

  rtq_core dut (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(start_i), .op_i(op_i), .quant_step_index_i(step_i),
    .luma_i(luma_i), .intra_i(intra_i), .blk_i(blk_i), .pred_i(pred_i), .busy_o(busy_o), .done_o(done_o),
    .evt_valid_o(evt_valid_o), .evt_run_o(evt_run_o), .evt_level_o(evt_level_o),
    .block_end_marker_o(block_end_marker_o), .end_codeword_o(end_codeword_o), .recon_o(recon_o),
    .chroma_dc_o(chroma_dc_o));
  rtq_far_side u_far (.clock_i(clock_i), .busy_i(busy_o), .pred_o(pred_i));

  // 125 MHz
  always #4 clock_i = ~clock_i;

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // hang guard; the whole sequence needs far fewer cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end

  function automatic int cmap(input int q);
    int hi [14] = '{17, 18, 19, 20, 20, 21, 22, 22, 23, 23, 24, 24, 25, 25};
    return (q < 18) ? q : hi[q - 18];
  endfunction : cmap

  // one separable pass over four lanes, no normalisation
  function automatic void pass(ref longint m [16], input bit inv, input bit rows);
    longint a, b, c, d;
    int ix [4];
    for (int l = 0; l < 4; l++) begin
      for (int k = 0; k < 4; k++) ix[k] = rows ? l * 4 + k : k * 4 + l;
      a = m[ix[0]];
      b = m[ix[1]];
      c = m[ix[2]];
      d = m[ix[3]];
      m[ix[0]] = inv ? 13 * a + 17 * b + 13 * c + 7 * d : 13 * (a + b + c + d);
      m[ix[1]] = inv ? 13 * a + 7 * b - 13 * c - 17 * d : 17 * a + 7 * b - 7 * c - 17 * d;
      m[ix[2]] = inv ? 13 * a - 7 * b - 13 * c + 17 * d : 13 * (a - b - c + d);
      m[ix[3]] = inv ? 13 * a - 17 * b + 13 * c - 7 * d : 7 * a - 17 * b + 17 * c - 7 * d;
    end
  endfunction : pass

  // same sign patterns both ways; division truncates toward zero
  function automatic void had2(ref longint m [16]);
    longint a = m[0], b = m[1], c = m[2], d = m[3];
    m[0] = (a + b + c + d) / 2;
    m[1] = (a - b + c - d) / 2;
    m[2] = (a + b - c - d) / 2;
    m[3] = (a - b - c + d) / 2;
  endfunction : had2

  function automatic longint qnt(input longint k, input int q);
    longint g = ((k < 0 ? -k : k) * longint'(RTQ_QTAB[q]) + 64'sh80000) >>> 20;
    return (k < 0) ? -g : g;
  endfunction : qnt

  // one scan segment: run/level pairs, then a block end
  function automatic void seg(input longint m [16], input int mode, input int lo, input int hi);
    int run = 0;
    int pos;
    for (int p = lo; p < hi; p++) begin
      pos = (mode == 0) ? RTQ_SCAN_SINGLE[p] : (mode == 1) ? RTQ_SCAN_DOUBLE[p] : p;
      if (m[pos] != 0) begin
        exq.push_back({2'h0, 4'(run), 32'(m[pos])});
        run = 0;
      end else begin
        run++;
      end
    end
    exq.push_back({2'h3, 4'h0, 32'h0});
  endfunction : seg

  function automatic void model(input rtq_op_t op, input int q, input bit lum, input bit intr,
                                input logic [511:0] blk, input logic [127:0] pred, output logic [127:0] res);
    longint m [16];
    longint v;
    int qq;
    qq = (lum && op < RTQ_OP_DCF) ? q : cmap(q);
    res = 128'h0;
    exq.delete();
    for (int i = 0; i < 16; i++) m[i] = $signed(blk[32 * i +: 32]);
    if (op == RTQ_OP_INV || op == RTQ_OP_DCI) begin
      for (int i = 0; i < 16; i++) m[i] = m[i] * longint'(RTQ_DQTAB[qq]);
    end
    case (op)
      RTQ_OP_FWD: begin
        pass(m, 1'h0, 1'h0);
        pass(m, 1'h0, 1'h1);
        for (int i = 0; i < 16; i++) m[i] = qnt(m[i], qq);
        if (lum && intr && q < 24) begin
          seg(m, 1, 0, 8);
          seg(m, 1, 8, 16);
        end else begin
          seg(m, 0, lum ? 0 : 1, 16);
        end
      end
      RTQ_OP_INV: begin
        pass(m, 1'h1, 1'h0);
        pass(m, 1'h1, 1'h1);
        for (int i = 0; i < 16; i++) begin
          v = ((m[i] + 64'sh80000) >>> 20) + longint'(pred[8 * i +: 8]);
          res[8 * i +: 8] = (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : 8'(v);
        end
      end
      RTQ_OP_DCF: begin
        had2(m);
        for (int i = 0; i < 4; i++) m[i] = qnt(m[i], qq);
        seg(m, 2, 0, 4);
      end
      default: begin
        had2(m);
        for (int i = 0; i < 4; i++) res[32 * i +: 32] = 32'(m[i]);
      end
    endcase
  endfunction : model

  // starts in the current cycle, so consecutive calls run back to back in the done cycle
  task automatic run_op(input rtq_op_t op, input int q, input bit lum, input bit intr, input logic [511:0] blk,
                        input logic [127:0] pred, input int lat);
    logic [127:0] res;
    int n = 0;
    model(op, q, lum, intr, blk, pred, res);
    op_i = op;
    step_i = 5'(q);
    luma_i = lum;
    intra_i = intr;
    blk_i = blk;
    u_far.pred = pred;
    gotq.delete();
    start_i = 1'h1;
    while (n == 0 || (done_o !== 1'h1 && n < 60)) begin
      @(posedge clock_i);
      #1;
      n++;
      // an extra request while busy must be ignored
      if (n == 1 || (n == 2 && poke)) start_i = (n == 1) && poke;
      if (n == 1 && poke) op_i = RTQ_OP_DCI;
      if (evt_valid_o === 1'h1) gotq.push_back({block_end_marker_o, end_codeword_o, evt_run_o, evt_level_o});
    end
    if (lat > 0) check(128'(n), 128'(lat));
    check(128'(gotq.size()), 128'(exq.size()));
    for (int i = 0; i < exq.size() && i < gotq.size(); i++) check(128'(gotq[i]), 128'(exq[i]));
    if (op == RTQ_OP_INV) check(recon_o, res);
    if (op == RTQ_OP_DCI) check(chroma_dc_o, res);
  endtask : run_op

  initial begin
    logic [511:0] blk;
    logic [127:0] pred;
    rtq_op_t op;
    bit intr;
    int lat;
    repeat (6) @(posedge clock_i);
    #1;
    nrst_i = 1'h1;
    // every op at every step index, both block kinds, sparse random data
    for (int k = 0; k < 512; k++) begin
      op = rtq_op_t'(k % 4);
      blk = 512'h0;
      for (int i = 0; i < 16; i++) begin
        case (op)
          RTQ_OP_FWD: blk[32 * i +: 32] = ($random(seed) % 3 == 0) ? $random(seed) % 256 : 0;
          RTQ_OP_INV: blk[32 * i +: 32] = ((i > 0 || k[2]) && $random(seed) % 3 == 0) ? $random(seed) % 3 : 0;
          default: blk[32 * i +: 32] = (i < 4) ? $random(seed) % (op == RTQ_OP_DCF ? 200000 : 50) : 0;
        endcase
      end
      pred = {$random(seed), $random(seed), $random(seed), $random(seed)};
      intr = (k / 16 == 23 || k / 16 == 24) || ($random(seed) % 2 == 0);
      // forward: four cycles plus scan positions plus one per block end
      lat = (op == RTQ_OP_INV) ? 4 : (op == RTQ_OP_DCI) ? 2 : (op == RTQ_OP_DCF) ? 8 :
            (k[2] && intr && k / 16 < 24) ? 22 : k[2] ? 21 : 20;
      poke = (k % 5 == 1) && op != RTQ_OP_DCI;
      run_op(op, k / 16, k[2], intr, blk, pred, lat);
    end
    // flat residual leaves only the dc coefficient; chroma ac skips that position
    poke = 1'h0;
    blk = {16{32'h0000_0009}};
    run_op(RTQ_OP_FWD, 0, 1'h1, 1'h0, blk, 128'h0, 21);
    run_op(RTQ_OP_FWD, 0, 1'h1, 1'h1, blk, 128'h0, 22);
    run_op(RTQ_OP_FWD, 0, 1'h0, 1'h0, blk, 128'h0, 20);
    // reset in mid-operation clears busy, done and event valid, and leaves the two result buses equal to each other
    start_i = 1'h1;
    @(posedge clock_i);
    #1;
    start_i = 1'h0;
    nrst_i = 1'h0;
    #1;
    check(128'({busy_o, done_o, evt_valid_o}), 128'h0);
    check(recon_o ^ chroma_dc_o, 128'h0);
    @(posedge clock_i);
    #1;
    nrst_i = 1'h1;
    // large levels drive reconstruction into both clip limits
    run_op(RTQ_OP_INV, 31, 1'h1, 1'h0, {16{32'h0000_0002}}, {16{8'hF0}}, 4);
    run_op(RTQ_OP_INV, 31, 1'h1, 1'h0, {16{32'hFFFF_FFFE}}, {16{8'h10}}, 4);
    give_verdict();
  end
endmodule : test_residual_transform_quant
